// file: design/atatf_decode.sv
// ATA task file register decode and command launch, device side
//
// Contract
// RQ1 - No block or unused control address: float, ignore
// RQ2 - Control 110 alt status/devctl; 111 drive address
// RQ3 - Command block maps 000..111 to task registers
// RQ4 - Route data by selects, read and write strobes
// RQ5 - LBA bits spread over sector, cylinders, head nibble
// RQ6 - Alternate status equals primary status bits
// RQ7 - Alternate status read leaves interrupt pending
// RQ8 - Command starts when command register written
// RQ9 - Host loads parameters before command write
// RQ10 - Cylinder high updated to current cylinder
// RQ11 - Cylinder low updated to current cylinder
// RQ12 - LBA: cylinder high gets LBA 16-23
// RQ13 - LBA: cylinder low gets LBA 8-15
// RQ14 - Cylinder high keeps two layers for 48-bit
// RQ15 - Cylinder low keeps two layers for 48-bit
// RQ16 - Power query in idle returns ff, never 80
// RQ17 - Download aborted while security locked
// RQ18 - Streaming completion limit at least 50 ms
// RQ19 - Streaming in standby waits for spin-up
// RQ20 - Recovery limit under 6.5 s aborts command
// RQ21 - Recovery-limited command in standby waits spin-up
// RQ22 - Hardware reset may differ from power-on reset
`timescale 1ns/100ps
`include "atatf_map.svh"
module atatf_decode
   import atatf_pkg::*;
#(
   parameter int CLK_MHZ = 100,
   parameter logic [7:0] CMD_PWRCHK = 8'he5,
   parameter logic [7:0] CMD_DNLOAD = 8'h92,
   parameter logic [7:0] CMD_STREAM = 8'h25
)
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clk_en,
   // Host pins, active-low strobes and selects
   input wire logic cs0_n,
   input wire logic cs1_n,
   input wire logic [2:0] da,
   input wire logic dior_n,
   input wire logic diow_n,
   input wire logic [15:0] dd_in,
   output logic [15:0] dd_out,
   output logic dd_oe_n,
   // Drive core side
   input wire logic hard_reset,
   input wire logic sec_locked,
   input wire logic spin_ready,
   input wire logic pwr_idle,
   input wire logic [15:0] erc_limit_ds,
   input wire logic [15:0] cctl_limit_ms,
   input wire logic cmd_done,
   input wire logic cmd_err,
   input wire logic [27:0] cur_addr,
   input wire logic [7:0] drv_addr_in,
   input wire logic [15:0] rd_data,
   output logic [15:0] wr_data,
   output logic wr_data_stb,
   output logic rd_data_stb,
   output logic [7:0] cmd_code,
   output logic cmd_start,
   output logic [47:0] cmd_lba,
   output logic [15:0] cctl_eff_ms,
   output logic intrq,
   output logic soft_reset
);
   initial
   begin
      if (CLK_MHZ < 1)
         $error("atatf_decode: CLK_MHZ must be positive");
   end

   // ----------------------------------------------------------------
   // Pin synchronisers: a change counts once stages two and three agree
   // ----------------------------------------------------------------
   localparam int NPIN = 23;
   localparam logic [NPIN-1:0] PIN_IDLE = {16'h0000, 7'h7f};
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] s1_q;
   logic [NPIN-1:0] s2_q;
   logic [NPIN-1:0] s3_q;
   logic [NPIN-1:0] pin_q;
   assign pin_raw = {dd_in, cs0_n, cs1_n, da, dior_n, diow_n};
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s1_q <= PIN_IDLE;
         s2_q <= PIN_IDLE;
         s3_q <= PIN_IDLE;
         pin_q <= PIN_IDLE;
      end
      else if (clk_en)
      begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         pin_q <= (s2_q & s3_q) | (pin_q & (s2_q ^ s3_q));
      end
   end

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   logic cmd_sel;
   logic ctl_sel;
   logic [2:0] a;
   logic rd_lvl;
   logic wr_lvl;
   logic rd_prev_q;
   logic wr_prev_q;
   logic rd_rise;
   logic wr_end;
   assign cmd_sel = !pin_q[6] && pin_q[5];
   assign ctl_sel = pin_q[6] && !pin_q[5];
   assign a = pin_q[4:2];
   assign rd_lvl = !pin_q[1];
   assign wr_lvl = !pin_q[0];
   assign rd_rise = rd_lvl && !rd_prev_q;
   assign wr_end = !wr_lvl && wr_prev_q;
   // Both selects or none decode to nothing: float and ignore
   wire ctl_alt = ctl_sel && a == `ATATF_A_ALTCTL; // RQ1 RQ2
   wire ctl_drv = ctl_sel && a == `ATATF_A_DRVADDR; // RQ2
   wire hit = cmd_sel || ctl_alt || ctl_drv; // RQ1
   wire wr_hit = wr_end && (cmd_sel || ctl_alt); // RQ1 RQ4
   wire wr_cmd = wr_hit && cmd_sel && a == `ATATF_A_STATCMD; // RQ8
   wire wr_ctl = wr_hit && ctl_alt; // RQ2
   wire wr_reg = wr_hit && cmd_sel;
   // Status read acknowledges interrupt; alternate read does not
   wire rd_stat_ack = rd_rise && cmd_sel && a == `ATATF_A_STATCMD; // RQ7

   // ----------------------------------------------------------------
   // Task file registers
   // ----------------------------------------------------------------
   logic [7:0] feat_q;
   logic [7:0] err_q;
   logic [7:0] secnt_q;
   logic [7:0] secnt_prev_q;
   logic [7:0] secnum_q;
   logic [7:0] secnum_prev_q;
   logic [7:0] cyllo_q;
   logic [7:0] cyllo_prev_q;
   logic [7:0] cylhi_q;
   logic [7:0] cylhi_prev_q;
   logic [7:0] devhead_q;
   logic [7:0] devctl_q;
   logic [7:0] status_q;
   logic [7:0] cmd_q;
   logic hob;
   logic lba_mode;
   assign hob = devctl_q[`ATATF_DC_HOB];
   assign lba_mode = devhead_q[`ATATF_DH_LBA];
   wire [7:0] d8 = pin_q[14:7];

   // HOB selects the earlier layer on reads of the layered registers
   wire [7:0] secnt_rd = hob ? secnt_prev_q : secnt_q;
   wire [7:0] secnum_rd = hob ? secnum_prev_q : secnum_q;
   wire [7:0] cyllo_rd = hob ? cyllo_prev_q : cyllo_q; // RQ15
   wire [7:0] cylhi_rd = hob ? cylhi_prev_q : cylhi_q; // RQ14
   // Alternate status is the very same flop set as primary status
   wire [7:0] alt_status = status_q; // RQ6

   logic [15:0] rd_mux;
   always_comb
   begin
      rd_mux = 16'h0000;
      if (ctl_alt)
         rd_mux = {8'h00, alt_status}; // RQ2 RQ6
      else if (ctl_drv)
         rd_mux = {8'h00, drv_addr_in}; // RQ2
      else if (cmd_sel)
      begin
         unique case (a) // RQ3 RQ4
            `ATATF_A_DATA: rd_mux = rd_data;
            `ATATF_A_ERRFEAT: rd_mux = {8'h00, err_q};
            `ATATF_A_SECCNT: rd_mux = {8'h00, secnt_rd};
            `ATATF_A_SECNUM: rd_mux = {8'h00, secnum_rd};
            `ATATF_A_CYLLO: rd_mux = {8'h00, cyllo_rd};
            `ATATF_A_CYLHI: rd_mux = {8'h00, cylhi_rd};
            `ATATF_A_DEVHEAD: rd_mux = {8'h00, devhead_q};
            `ATATF_A_STATCMD: rd_mux = {8'h00, status_q};
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Command engine
   // ----------------------------------------------------------------
   atatf_state_type state_q;
   atatf_kind_type kind_q;
   logic abort_now;
   logic [15:0] cctl_d;
   atatf_kind_type kind_d;
   assign kind_d = (d8 == CMD_PWRCHK) ? ATATF_K_PWRCHK :
                   (d8 == CMD_DNLOAD) ? ATATF_K_DNLOAD :
                   (d8 == CMD_STREAM) ? ATATF_K_STREAM : ATATF_K_PLAIN;
   assign abort_now = (kind_d == ATATF_K_DNLOAD && sec_locked) || // RQ17
                      (erc_limit_ds != 16'h0000 &&
                       erc_limit_ds < 16'(`ATATF_ERC_MIN_DS)); // RQ20
   assign cctl_d = (cctl_limit_ms < 16'(`ATATF_CCTL_MIN_MS)) ?
                   16'(`ATATF_CCTL_MIN_MS) : cctl_limit_ms; // RQ18
   // A streaming command or a set recovery limit means completion waits on spin-up
   wire needs_spin = (kind_q == ATATF_K_STREAM) || (erc_limit_ds != 16'h0000); // RQ19 RQ21
   wire complete = state_q == ATATF_EXEC && cmd_done && !(needs_spin && !spin_ready);
   wire [27:0] lba_now = cur_addr;

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rd_prev_q <= 1'b0;
         wr_prev_q <= 1'b0;
         feat_q <= 8'h00;
         secnt_prev_q <= 8'h00;
         secnum_prev_q <= 8'h00;
         cyllo_prev_q <= 8'h00;
         cylhi_prev_q <= 8'h00;
         cmd_q <= 8'h00;
         kind_q <= ATATF_K_PLAIN;
         cctl_eff_ms <= 16'(`ATATF_CCTL_MIN_MS);
      end
      else if (clk_en)
      begin
         rd_prev_q <= rd_lvl;
         wr_prev_q <= wr_lvl;
         if (wr_reg && a == `ATATF_A_ERRFEAT)
            feat_q <= d8;
         // Each write pushes the current byte down into the earlier layer
         if (wr_reg && a == `ATATF_A_SECCNT)
            secnt_prev_q <= secnt_q;
         if (wr_reg && a == `ATATF_A_SECNUM)
            secnum_prev_q <= secnum_q;
         if (wr_reg && a == `ATATF_A_CYLLO)
            cyllo_prev_q <= cyllo_q; // RQ15
         if (wr_reg && a == `ATATF_A_CYLHI)
            cylhi_prev_q <= cylhi_q; // RQ14
         if (wr_cmd)
         begin
            cmd_q <= d8; // RQ8
            kind_q <= kind_d;
            cctl_eff_ms <= cctl_d; // RQ18
         end
      end
   end

   // Registers the host writes and the core updates at completion
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         secnt_q <= `ATATF_RST_SECCNT;
         secnum_q <= `ATATF_RST_SECNUM;
         cyllo_q <= 8'h00;
         cylhi_q <= 8'h00;
         devhead_q <= `ATATF_RST_DEVHEAD;
         err_q <= `ATATF_RST_ERROR;
      end
      else if (clk_en)
      begin
         if (complete)
         begin
            // Same bits serve cylinder and LBA; host picks the meaning
            secnum_q <= lba_now[7:0]; // RQ5
            cyllo_q <= lba_now[15:8]; // RQ11 RQ13
            cylhi_q <= lba_now[23:16]; // RQ10 RQ12
            devhead_q[3:0] <= lba_now[27:24]; // RQ5
            err_q <= cmd_err ? 8'h04 : 8'h00;
            if (kind_q == ATATF_K_PWRCHK)
               secnt_q <= pwr_idle ? `ATATF_PWR_IDLE : 8'h00; // RQ16
         end
         else if (state_q == ATATF_IDLE && wr_cmd && abort_now)
            err_q <= 8'h04; // RQ17 RQ20
         else if (wr_reg)
         begin
            unique case (a) // RQ3 RQ4
               `ATATF_A_SECCNT: secnt_q <= d8;
               `ATATF_A_SECNUM: secnum_q <= d8;
               `ATATF_A_CYLLO: cyllo_q <= d8;
               `ATATF_A_CYLHI: cylhi_q <= d8;
               `ATATF_A_DEVHEAD: devhead_q <= d8;
               default: ;
            endcase
         end
      end
   end

   // Device control: any command block register write clears HOB; hard reset may differ
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         devctl_q <= `ATATF_RST_DEVCTL;
      else if (clk_en)
      begin
         if (wr_ctl)
            devctl_q <= d8; // RQ2
         else if (wr_reg)
            devctl_q[`ATATF_DC_HOB] <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_q <= ATATF_IDLE;
         status_q <= `ATATF_RST_STATUS;
         cmd_start <= 1'b0;
         intrq <= 1'b0;
      end
      else if (clk_en)
      begin
         cmd_start <= 1'b0;
         // Completion's set beats an acknowledge in the same cycle
         if (rd_stat_ack)
            intrq <= 1'b0; // RQ7
         if (hard_reset)
         begin
            // Hard reset keeps the task file; only the engine restarts
            state_q <= ATATF_IDLE; // RQ22
            status_q <= `ATATF_RST_STATUS;
            intrq <= 1'b0;
         end
         else
         begin
            unique case (state_q)
               ATATF_IDLE:
                  if (wr_cmd)
                  begin
                     if (abort_now)
                     begin
                        status_q <= 8'h51;
                        intrq <= !devctl_q[`ATATF_DC_NIEN];
                     end
                     else
                     begin
                        state_q <= ATATF_EXEC; // RQ8
                        status_q <= 8'h80;
                        cmd_start <= 1'b1;
                     end
                  end
               ATATF_EXEC:
                  if (needs_spin && !spin_ready)
                     state_q <= ATATF_SPIN; // RQ19 RQ21
                  else if (cmd_done)
                     state_q <= ATATF_DONE;
               ATATF_SPIN:
                  if (spin_ready)
                     state_q <= ATATF_EXEC; // RQ19 RQ21
               ATATF_DONE:
               begin
                  state_q <= ATATF_IDLE;
                  status_q <= {7'h28, err_q[`ATATF_ER_ABRT]};
                  intrq <= !devctl_q[`ATATF_DC_NIEN];
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Output registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         dd_out <= 16'h0000;
         dd_oe_n <= 1'b1;
         wr_data <= 16'h0000;
         wr_data_stb <= 1'b0;
         rd_data_stb <= 1'b0;
         cmd_code <= 8'h00;
         cmd_lba <= 48'h0;
         soft_reset <= 1'b0;
      end
      else if (clk_en)
      begin
         dd_out <= rd_mux; // RQ4
         dd_oe_n <= !(rd_lvl && hit); // RQ1
         wr_data <= pin_q[22:7];
         wr_data_stb <= wr_reg && a == `ATATF_A_DATA;
         rd_data_stb <= rd_rise && cmd_sel && a == `ATATF_A_DATA;
         cmd_code <= cmd_q;
         cmd_lba <= {cylhi_prev_q, cyllo_prev_q, secnum_prev_q,
                     cylhi_q, cyllo_q, secnum_q}; // RQ5 RQ14 RQ15
         soft_reset <= devctl_q[`ATATF_DC_SRST];
      end
   end
endmodule : atatf_decode

// file: design/atatf_map.svh
// Offsets, field positions, reset values and timing counts of the task file decode
`ifndef ATATF_MAP_SVH
`define ATATF_MAP_SVH
// Command block addresses (da[2:0])
`define ATATF_A_DATA 3'h0
`define ATATF_A_ERRFEAT 3'h1
`define ATATF_A_SECCNT 3'h2
`define ATATF_A_SECNUM 3'h3
`define ATATF_A_CYLLO 3'h4
`define ATATF_A_CYLHI 3'h5
`define ATATF_A_DEVHEAD 3'h6
`define ATATF_A_STATCMD 3'h7
// Control block addresses
`define ATATF_A_ALTCTL 3'h6
`define ATATF_A_DRVADDR 3'h7
// Field positions
`define ATATF_DC_HOB 7
`define ATATF_DC_SRST 2
`define ATATF_DC_NIEN 1
`define ATATF_DH_LBA 6
`define ATATF_DH_DRV 4
`define ATATF_ST_BSY 7
`define ATATF_ST_RDY 6
`define ATATF_ST_DRQ 3
`define ATATF_ST_ERR 0
`define ATATF_ER_ABRT 2
// Reset values
`define ATATF_RST_STATUS 8'h50
`define ATATF_RST_ERROR 8'h01
`define ATATF_RST_DEVHEAD 8'ha0
`define ATATF_RST_SECCNT 8'h01
`define ATATF_RST_SECNUM 8'h01
`define ATATF_RST_DEVCTL 8'h08
// Power mode answer and the value never returned
`define ATATF_PWR_IDLE 8'hff
`define ATATF_PWR_BAD 8'h80
// Time limits in ms, tenths of seconds in the second case
`define ATATF_CCTL_MIN_MS 50
`define ATATF_ERC_MIN_DS 65
`endif

// file: design/atatf_pkg.sv
// Types shared by the task file decode
package atatf_pkg;
   typedef enum logic [1:0] {
      ATATF_IDLE = 2'b00,
      ATATF_EXEC = 2'b01,
      ATATF_SPIN = 2'b10,
      ATATF_DONE = 2'b11
   } atatf_state_type;
   typedef enum logic [1:0] {
      ATATF_K_PLAIN = 2'b00,
      ATATF_K_PWRCHK = 2'b01,
      ATATF_K_DNLOAD = 2'b10,
      ATATF_K_STREAM = 2'b11
   } atatf_kind_type;
endpackage : atatf_pkg

// file: sim/atatf_decode_checker.sv
// Port checker of the task file decode
`timescale 1ns/100ps
module atatf_decode_checker (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic cs0_n,
   input wire logic cs1_n,
   input wire logic [2:0] da,
   input wire logic dior_n,
   input wire logic diow_n,
   input wire logic dd_oe_n,
   input wire logic cmd_start,
   input wire logic cmd_done,
   input wire logic [47:0] cmd_lba,
   input wire logic [15:0] cctl_eff_ms,
   input wire logic intrq
);
   // ---------------------------------------------
   // Ages since a write strobe ended and since a command event
   // ---------------------------------------------
   logic diow_q;
   logic [3:0] wr_age_q;
   logic [3:0] ev_age_q;
   logic [3:0] wr_age_d;
   logic [3:0] ev_age_d;
   assign wr_age_d = (diow_n && !diow_q) ? 4'h0 : wr_age_q + {3'h0, wr_age_q != 4'hf};
   assign ev_age_d = (cmd_done || cmd_start) ? 4'h0 : ev_age_q + {3'h0, ev_age_q != 4'hf};
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         diow_q <= 1'b1;
         wr_age_q <= 4'hf;
         // Reset release counts as an event: outputs leave their reset values
         ev_age_q <= 4'h0;
      end
      else
      begin
         diow_q <= diow_n;
         wr_age_q <= wr_age_d;
         ev_age_q <= ev_age_d;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   property p_drive_cause;
      $fell(dd_oe_n) |-> $past(dior_n, 3) == 1'b0 && $past(cs0_n, 3) != $past(cs1_n, 3);
   endproperty
   a_drive_cause: assert property (p_drive_cause) else $error("drive without read");
   property p_ctl_unused;
      $fell(dd_oe_n) && $past(cs1_n, 3) == 1'b0 |-> $past(da, 3) >= 3'h6;
   endproperty
   a_ctl_unused: assert property (p_ctl_unused) else $error("unused control drive");
   property p_no_drive;
      dior_n [*8] |-> dd_oe_n;
   endproperty
   a_no_drive: assert property (p_no_drive) else $error("bus driven while idle");
   property p_start_pulse;
      cmd_start |=> !cmd_start;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start too long");
   property p_start_write;
      cmd_start |-> wr_age_q >= 4'd2 && wr_age_q <= 4'd9;
   endproperty
   a_start_write: assert property (p_start_write) else $error("start without write");
   property p_cctl_floor;
      cctl_eff_ms >= 16'd50;
   endproperty
   a_cctl_floor: assert property (p_cctl_floor) else $error("limit below floor");
   property p_lba_cause;
      $changed(cmd_lba) |-> wr_age_q <= 4'd9 || ev_age_q <= 4'd3;
   endproperty
   a_lba_cause: assert property (p_lba_cause) else $error("address moved alone");
   property p_intrq_cause;
      $rose(intrq) |-> ev_age_q <= 4'd4;
   endproperty
   a_intrq_cause: assert property (p_intrq_cause) else $error("stray interrupt");
endmodule : atatf_decode_checker

// file: sim/atatf_decode_tb.sv
// Self-checking bench of the task file decode
`timescale 1ns/100ps
`include "atatf_map.svh"
module atatf_decode_tb;
   localparam logic [1:0] CB = 2'b01;
   localparam logic [1:0] CT = 2'b10;
   logic sys_clk, resetn, clk_en, hard_reset, sec_locked, spin_ready, pwr_idle;
   logic cs0_n, cs1_n, dior_n, diow_n, dd_oe_n, cmd_done, cmd_err, cmd_start, intrq, ro;
   logic wr_data_stb, rd_data_stb, soft_reset;
   logic [2:0] da;
   logic [7:0] drv_addr_in, cmd_code;
   logic [15:0] dd_in, dd_out, erc_limit_ds, cctl_limit_ms, rd_data, wr_data, cctl_eff_ms, rv;
   logic [27:0] cur_addr;
   logic [47:0] cmd_lba;
   int fails, checks, starts, cyc, wstb, rstb;
   logic [4:0] bad [4] = '{5'b10000, 5'b10101, 5'b11010, 5'b00111};
   atatf_decode uut (.sys_clk, .resetn, .clk_en, .cs0_n, .cs1_n, .da, .dior_n, .diow_n,
      .dd_in, .dd_out, .dd_oe_n, .hard_reset, .sec_locked, .spin_ready, .pwr_idle,
      .erc_limit_ds, .cctl_limit_ms, .cmd_done, .cmd_err, .cur_addr, .drv_addr_in, .rd_data,
      .wr_data, .wr_data_stb, .rd_data_stb, .cmd_code, .cmd_start, .cmd_lba,
      .cctl_eff_ms, .intrq, .soft_reset);
   atatf_host host (.sys_clk, .dd_out, .dd_oe_n, .cs0_n, .cs1_n, .da, .dior_n, .diow_n, .dd_in);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [1:0] s, input logic [2:0] a, input logic [15:0] d);
      host.acc(s, a, 1'b1, d, rv, ro);
   endtask : wr
   task automatic rd(input logic [1:0] s, input logic [2:0] a, output logic [15:0] d);
      host.acc(s, a, 1'b0, 16'h0, d, ro);
   endtask : rd
   task automatic cmd(input logic [7:0] c, output logic [15:0] st);
      wr(CB, `ATATF_A_STATCMD, {8'h0, c});
      rd(CB, `ATATF_A_STATCMD, st);
   endtask : cmd
   task automatic t_map();
      logic [15:0] v;
      int n;
      rd(CB, `ATATF_A_STATCMD, v);
      chk(v, 16'h0050);
      wr(CB, `ATATF_A_SECCNT, 16'h0012);
      wr(CB, `ATATF_A_ERRFEAT, 16'h0056);
      n = wstb;
      wr(CB, `ATATF_A_DATA, 16'hbeef);
      chk(wr_data, 16'hbeef);
      chk(16'(wstb - n), 16'h1);
      wr(2'b11, `ATATF_A_SECCNT, 16'h0077);
      rd(CB, `ATATF_A_SECCNT, v);
      chk(v, 16'h0012);
      rd(CB, `ATATF_A_ERRFEAT, v);
      chk(v, 16'h0001);
      n = rstb;
      rd(CB, `ATATF_A_DATA, v);
      chk(v, rd_data);
      chk(16'(rstb - n), 16'h1);
      wr(CT, `ATATF_A_DRVADDR, 16'h00ff);
      rd(CT, `ATATF_A_DRVADDR, v);
      chk(v, {8'h0, drv_addr_in});
      foreach (bad[i])
      begin
         rd(bad[i][4:3], bad[i][2:0], v);
         chk({15'h0, ro}, 16'h1);
      end
   endtask : t_map
   task automatic t_layer();
      logic [15:0] v;
      wr(CB, `ATATF_A_CYLLO, 16'h0011);
      wr(CB, `ATATF_A_CYLLO, 16'h0022);
      wr(CB, `ATATF_A_CYLHI, 16'h0033);
      wr(CB, `ATATF_A_CYLHI, 16'h0044);
      chk(cmd_lba[15:0], 16'h2201);
      chk({8'h0, cmd_lba[39:32]}, 16'h0011);
      chk({8'h0, cmd_lba[23:16]}, 16'h0044);
      chk({8'h0, cmd_lba[47:40]}, 16'h0033);
      wr(CT, `ATATF_A_ALTCTL, 16'h0084);
      chk({15'h0, soft_reset}, 16'h1);
      rd(CB, `ATATF_A_CYLLO, v);
      chk(v, 16'h0011);
      rd(CB, `ATATF_A_CYLHI, v);
      chk(v, 16'h0033);
      wr(CB, `ATATF_A_ERRFEAT, 16'h0000);
      rd(CB, `ATATF_A_CYLLO, v);
      chk(v, 16'h0022);
      wr(CT, `ATATF_A_ALTCTL, 16'h0000);
      chk({15'h0, soft_reset}, 16'h0);
   endtask : t_layer
   task automatic t_cmd();
      logic [15:0] v, s;
      int n;
      cmd_done <= 1'b0;
      wr(CB, `ATATF_A_DEVHEAD, 16'h00e0);
      n = starts;
      wr(CB, `ATATF_A_STATCMD, 16'h0020);
      chk(16'(starts - n), 16'h1);
      chk({8'h0, cmd_code}, 16'h0020);
      rd(CT, `ATATF_A_ALTCTL, v);
      chk(v, 16'h0080);
      rd(CB, `ATATF_A_STATCMD, s);
      chk(s, v);
      cmd_done <= 1'b1;
      for (int i = 0; i < 20 && intrq !== 1'b1; i++)
         @(posedge sys_clk);
      rd(CT, `ATATF_A_ALTCTL, v);
      chk({15'h0, intrq}, 16'h1);
      rd(CB, `ATATF_A_STATCMD, v);
      chk({15'h0, intrq}, 16'h0);
      rd(CB, `ATATF_A_SECNUM, v);
      chk(v, 16'h00ef);
      rd(CB, `ATATF_A_CYLLO, v);
      chk(v, 16'h00cd);
      rd(CB, `ATATF_A_CYLHI, v);
      chk(v, 16'h00ab);
      rd(CB, `ATATF_A_DEVHEAD, v);
      chk({12'h0, v[3:0]}, 16'h9);
   endtask : t_cmd
   task automatic t_special();
      logic [15:0] v;
      for (int p = 0; p < 2; p++)
      begin
         pwr_idle <= p[0];
         cmd(8'he5, v);
         rd(CB, `ATATF_A_SECCNT, v);
         chk(v, p ? 16'h00ff : 16'h0000);
      end
      sec_locked <= 1'b1;
      cmd(8'h92, v);
      chk(v, 16'h0051);
      rd(CB, `ATATF_A_ERRFEAT, v);
      chk(v, 16'h0004);
      sec_locked <= 1'b0;
      erc_limit_ds <= 16'd64;
      cmd(8'h20, v);
      chk(v, 16'h0051);
      erc_limit_ds <= 16'd65;
      cmd(8'h20, v);
      chk({15'h0, v[0]}, 16'h0);
   endtask : t_special
   task automatic t_stream();
      logic [15:0] v;
      for (int k = 0; k < 2; k++)
      begin
         spin_ready <= 1'b0;
         erc_limit_ds <= k ? 16'd100 : 16'd0;
         wr(CB, `ATATF_A_STATCMD, k ? 16'h0020 : 16'h0025);
         rd(CT, `ATATF_A_ALTCTL, v);
         chk({15'h0, v[7]}, 16'h1);
         spin_ready <= 1'b1;
         rd(CB, `ATATF_A_STATCMD, v);
         chk({15'h0, v[7]}, 16'h0);
      end
      chk(cctl_eff_ms, 16'd50);
      cctl_limit_ms <= 16'd200;
      cmd(8'h25, v);
      chk(cctl_eff_ms, 16'd200);
   endtask : t_stream
   task automatic t_hrst();
      logic [15:0] v;
      cmd_done <= 1'b0;
      wr(CB, `ATATF_A_STATCMD, 16'h0020);
      rd(CT, `ATATF_A_ALTCTL, v);
      chk(v, 16'h0080);
      hard_reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      hard_reset <= 1'b0;
      cmd_done <= 1'b1;
      rd(CB, `ATATF_A_CYLLO, v);
      chk(v, 16'h00cd);
      rd(CB, `ATATF_A_STATCMD, v);
      chk(v, 16'h0050);
   endtask : t_hrst
   task automatic finish_test();
      if (fails == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      starts += int'(cmd_start === 1'b1);
      wstb += int'(wr_data_stb === 1'b1);
      rstb += int'(rd_data_stb === 1'b1);
      cyc++;
      if (cyc == 6000)
      begin
         fails++;
         finish_test();
      end
   end
   initial
   begin
      {resetn, hard_reset, sec_locked, pwr_idle, cmd_err} = 5'h0;
      {clk_en, spin_ready, cmd_done} = 3'h7;
      {erc_limit_ds, cctl_limit_ms, rd_data} = {16'h0, 16'd10, 16'h5aa5};
      {cur_addr, drv_addr_in} = {28'h9abcdef, 8'h3c};
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (5) @(posedge sys_clk);
      t_map();
      t_layer();
      t_cmd();
      t_special();
      t_stream();
      t_hrst();
      finish_test();
   end
endmodule : atatf_decode_tb
bind atatf_decode atatf_decode_checker u_chk (.sys_clk, .resetn, .cs0_n, .cs1_n, .da,
   .dior_n, .diow_n, .dd_oe_n, .cmd_start, .cmd_done, .cmd_lba, .cctl_eff_ms, .intrq);

// file: sim/atatf_host.sv
// Host controller model driving the task file pins
`timescale 1ns/100ps
module atatf_host (
   input wire logic sys_clk,
   input wire logic [15:0] dd_out,
   input wire logic dd_oe_n,
   output logic cs0_n,
   output logic cs1_n,
   output logic [2:0] da,
   output logic dior_n,
   output logic diow_n,
   output logic [15:0] dd_in
);
   initial
   begin
      cs0_n = 1'b1;
      cs1_n = 1'b1;
      da = 3'h0;
      dior_n = 1'b1;
      diow_n = 1'b1;
      dd_in = 16'hffff;
   end
   // Sel bit 0 picks the command block, bit 1 the control block
   task automatic acc(input logic [1:0] sel, input logic [2:0] a, input logic wr,
      input logic [15:0] wd, output logic [15:0] rdv, output logic oe);
      cs0_n <= ~sel[0];
      cs1_n <= ~sel[1];
      da <= a;
      dd_in <= wd;
      repeat (4) @(posedge sys_clk);
      dior_n <= wr;
      diow_n <= !wr;
      repeat (8) @(posedge sys_clk);
      rdv = dd_out;
      oe = dd_oe_n;
      dior_n <= 1'b1;
      diow_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
      cs0_n <= 1'b1;
      cs1_n <= 1'b1;
      // Released bus shows the inverse so stale data never looks valid
      dd_in <= ~wd;
      @(posedge sys_clk);
   endtask : acc
endmodule : atatf_host
